// >>> hw/bpc_pkg.sv
// Constants for the BCD line polarity and format register bank.
package bpc_pkg;
    localparam logic [3:0] REG_ID = 4'h0;
    localparam logic [3:0] REG_MANT = 4'h3;
    localparam logic [3:0] REG_EXPO = 4'h4;
    localparam logic [3:0] REG_FUNC = 4'h5;
    localparam logic [3:0] REG_DECP = 4'h6;
    localparam logic [3:0] REG_HSPOL = 4'h7;
    localparam logic [3:0] REG_DATAPOL = 4'h8;
    localparam logic [3:0] REG_FUNCPOL = 4'h9;
    localparam logic [3:0] REG_SIGNPOL = 4'hA;
    // Identity value is arbitrary.
    localparam logic [7:0] ID_VALUE = 8'h5A;
    // Reset values, single channel then dual channel.
    localparam logic [7:0] MANT_SINGLE = 8'h08;
    localparam logic [7:0] MANT_DUAL = 8'h44;
    localparam logic [7:0] EXPO_SINGLE = 8'h01;
    localparam logic [7:0] EXPO_DUAL = 8'h00;
    localparam logic [7:0] FUNC_SINGLE = 8'h01;
    localparam logic [7:0] FUNC_DUAL = 8'h11;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [3:0] FUNC_MAX = 4'hB;
    // Field positions in the sign/port register.
    localparam int SIGN_EXPB = 7;
    localparam int SIGN_MANB = 6;
    localparam int SIGN_EXPA = 5;
    localparam int SIGN_MANA = 4;
    localparam int NIB = 4;
endpackage

// >>> hw/bpc_invert.sv
// Registered pin-to-logic and logic-to-pin inversion of a group of lines.
`timescale 1ns/10ps
`default_nettype none
module bpc_invert #(
    parameter int W = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Sense, inbound pin level, outbound logic level.
    input wire logic [W-1:0] negTrue,
    input wire logic [W-1:0] pinIn,
    input wire logic [W-1:0] logicOut,
    // Inverted results.
    output logic [W-1:0] logicIn,
    output logic [W-1:0] pinOut
);
    logic [W-1:0] sync1_q;
    logic [W-1:0] sync2_q;

    // Two-stage synchroniser on the pin level.
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
        end
    end

    // Same inversion both ways so a round trip is transparent.
    always_ff @(posedge clk) begin
        if (rst) begin
            logicIn <= '0;
            pinOut <= '0;
        end else begin
            logicIn <= sync2_q ^ negTrue;
            pinOut <= logicOut ^ negTrue;
        end
    end
endmodule
`default_nettype wire

// >>> hw/bpc_regs.sv
// Format and polarity register bank with the polarity inversion paths.
`timescale 1ns/10ps
`default_nettype none
module bpc_regs
    import bpc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Reset default configuration switch, position 1 selects dual format.
    input wire logic resetDefaultConfigSwitch,
    // Register access port.
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regRvalid,
    // Transfer boundary, polarity snapshot is taken here.
    input wire logic xferStart,
    // Function digit lines, channel A and B.
    input wire logic [3:0] funcPinA,
    input wire logic [3:0] funcPinB,
    input wire logic [3:0] funcOutA,
    input wire logic [3:0] funcOutB,
    output logic [3:0] funcInA,
    output logic [3:0] funcInB,
    output logic [3:0] funcDrvA,
    output logic [3:0] funcDrvB,
    // Data digit lines, channel A and B.
    input wire logic [3:0] dataPinA,
    input wire logic [3:0] dataPinB,
    input wire logic [3:0] dataOutA,
    input wire logic [3:0] dataOutB,
    output logic [3:0] dataInA,
    output logic [3:0] dataInB,
    output logic [3:0] dataDrvA,
    output logic [3:0] dataDrvB,
    // Signs: exponent B, mantissa B, exponent A, mantissa A.
    input wire logic [3:0] signPin,
    input wire logic [3:0] signOut,
    output logic [3:0] signIn,
    output logic [3:0] signDrv,
    // Auxiliary nibble port.
    input wire logic [3:0] auxPin,
    input wire logic [3:0] auxOut,
    output logic [3:0] auxIn,
    output logic [3:0] auxDrv,
    // Register views for the formatter.
    output logic [7:0] mantCount,
    output logic [7:0] expoCount,
    output logic [7:0] funcCount,
    output logic [7:0] decPoint,
    output logic [7:0] handshakePol
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] mant_q;
    logic [7:0] expo_q;
    logic [7:0] func_q;
    logic [7:0] decp_q;
    logic [7:0] hspol_q;
    logic [7:0] datapol_q;
    logic [7:0] funcpol_q;
    logic [7:0] signpol_q;
    logic [7:0] actFunc_q;
    logic [7:0] actData_q;
    logic [7:0] actSign_q;
    logic sw1_q;
    logic sw2_q;
    logic [7:0] funcClip;

    // Address decode used by the register write processes and the read port.
    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction

    // Switch synchroniser; the strap is sampled only through the second stage.
    always_ff @(posedge clk) begin
        sw1_q <= resetDefaultConfigSwitch;
        sw2_q <= sw1_q;
    end

    // Function counts above 11 are held at 11 per channel.
    always_comb begin
        funcClip[3:0] = (regWdata[3:0] > FUNC_MAX) ? FUNC_MAX
                                                    : regWdata[3:0];
        funcClip[7:4] = (regWdata[7:4] > FUNC_MAX) ? FUNC_MAX
                                                    : regWdata[7:4];
    end

    ////////////////////////////////////////////////////////////////////////
    // Digit count and decimal point registers, low nibble channel A, high nibble B.
    always_ff @(posedge clk) begin
        if (rst) begin
            mant_q <= sw2_q ? MANT_DUAL : MANT_SINGLE;
            expo_q <= sw2_q ? EXPO_DUAL : EXPO_SINGLE;
            func_q <= sw2_q ? FUNC_DUAL : FUNC_SINGLE;
            decp_q <= ZERO_BYTE;
        end else if (regWrite) begin
            if (hit(regAddr, REG_MANT)) begin
                mant_q <= regWdata;
            end else if (hit(regAddr, REG_EXPO)) begin
                expo_q <= regWdata;
            end else if (hit(regAddr, REG_FUNC)) begin
                func_q <= funcClip;
            end else if (hit(regAddr, REG_DECP)) begin
                decp_q <= regWdata;
            end
        end
    end

    // Polarity registers, cleared by reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            hspol_q <= ZERO_BYTE;
            datapol_q <= ZERO_BYTE;
            funcpol_q <= ZERO_BYTE;
            signpol_q <= ZERO_BYTE;
        end else if (regWrite) begin
            if (hit(regAddr, REG_HSPOL)) begin
                hspol_q <= regWdata;
            end else if (hit(regAddr, REG_DATAPOL)) begin
                datapol_q <= regWdata;
            end else if (hit(regAddr, REG_FUNCPOL)) begin
                funcpol_q <= regWdata;
            end else if (hit(regAddr, REG_SIGNPOL)) begin
                signpol_q <= regWdata;
            end
        end
    end

    // Active polarity is loaded at a transfer start so a write never
    // changes the sense of the function, data, sign or aux lines in the middle of a transfer.
    always_ff @(posedge clk) begin
        if (rst) begin
            actFunc_q <= ZERO_BYTE;
            actData_q <= ZERO_BYTE;
            actSign_q <= ZERO_BYTE;
        end else if (xferStart) begin
            actFunc_q <= funcpol_q;
            actData_q <= datapol_q;
            actSign_q <= signpol_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port; reads change no state.
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata <= ZERO_BYTE;
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= regRead;
            if (!regRead) begin
                regRdata <= ZERO_BYTE;
            end else if (hit(regAddr, REG_ID)) begin
                regRdata <= ID_VALUE;
            end else if (hit(regAddr, REG_MANT)) begin
                regRdata <= mant_q;
            end else if (hit(regAddr, REG_EXPO)) begin
                regRdata <= expo_q;
            end else if (hit(regAddr, REG_FUNC)) begin
                regRdata <= func_q;
            end else if (hit(regAddr, REG_DECP)) begin
                regRdata <= decp_q;
            end else if (hit(regAddr, REG_HSPOL)) begin
                regRdata <= hspol_q;
            end else if (hit(regAddr, REG_DATAPOL)) begin
                regRdata <= datapol_q;
            end else if (hit(regAddr, REG_FUNCPOL)) begin
                regRdata <= funcpol_q;
            end else if (hit(regAddr, REG_SIGNPOL)) begin
                regRdata <= signpol_q;
            end else begin
                regRdata <= ZERO_BYTE;
            end
        end
    end

    // Register views for neighbouring logic.
    always_ff @(posedge clk) begin
        if (rst) begin
            mantCount <= ZERO_BYTE;
            expoCount <= ZERO_BYTE;
            funcCount <= ZERO_BYTE;
            decPoint <= ZERO_BYTE;
            handshakePol <= ZERO_BYTE;
        end else begin
            mantCount <= mant_q;
            expoCount <= expo_q;
            funcCount <= func_q;
            decPoint <= decp_q;
            handshakePol <= hspol_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Inversion paths for each line group.
    bpc_invert #(.W(NIB)) uFuncA (.clk(clk), .rst(rst),
        .negTrue(actFunc_q[3:0]), .pinIn(funcPinA), .logicOut(funcOutA),
        .logicIn(funcInA), .pinOut(funcDrvA));
    bpc_invert #(.W(NIB)) uFuncB (.clk(clk), .rst(rst),
        .negTrue(actFunc_q[7:4]), .pinIn(funcPinB), .logicOut(funcOutB),
        .logicIn(funcInB), .pinOut(funcDrvB));
    bpc_invert #(.W(NIB)) uDataA (.clk(clk), .rst(rst),
        .negTrue(actData_q[3:0]), .pinIn(dataPinA), .logicOut(dataOutA),
        .logicIn(dataInA), .pinOut(dataDrvA));
    bpc_invert #(.W(NIB)) uDataB (.clk(clk), .rst(rst),
        .negTrue(actData_q[7:4]), .pinIn(dataPinB), .logicOut(dataOutB),
        .logicIn(dataInB), .pinOut(dataDrvB));
    bpc_invert #(.W(NIB)) uSign (.clk(clk), .rst(rst),
        .negTrue({actSign_q[SIGN_EXPB], actSign_q[SIGN_MANB],
                  actSign_q[SIGN_EXPA], actSign_q[SIGN_MANA]}),
        .pinIn(signPin), .logicOut(signOut),
        .logicIn(signIn), .pinOut(signDrv));
    bpc_invert #(.W(NIB)) uAux (.clk(clk), .rst(rst),
        .negTrue(actSign_q[3:0]), .pinIn(auxPin), .logicOut(auxOut),
        .logicIn(auxIn), .pinOut(auxDrv));
endmodule
`default_nettype wire

// >>> dv/bpc_asserts.sv
// Checker of the polarity and format register bank ports.
`timescale 1ns/10ps
`default_nettype none
module bpc_asserts
    import bpc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic regRvalid,
    input wire logic [7:0] mantCount,
    // Polarity paths.
    input wire logic xferStart,
    input wire logic [3:0] funcOutA,
    input wire logic [3:0] funcOutB,
    input wire logic [3:0] funcDrvA,
    input wire logic [3:0] funcDrvB,
    input wire logic [3:0] signOut,
    input wire logic [3:0] signDrv,
    input wire logic [3:0] auxOut,
    input wire logic [3:0] auxDrv
);
    logic [7:0] fnQ, sgQ, fnAct, sgAct;
    // Shadows of the written and the active function and sign polarity bytes.
    always_ff @(posedge clk) begin
        if (rst) begin
            {fnQ, sgQ, fnAct, sgAct} <= 32'h0;
        end else begin
            if (regWrite && regAddr == REG_FUNCPOL) fnQ <= regWdata;
            if (regWrite && regAddr == REG_SIGNPOL) sgQ <= regWdata;
            if (xferStart) {fnAct, sgAct} <= {fnQ, sgQ};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rv; regRead |=> regRvalid; endproperty
    a_rv: assert property (p_rv) else $error("no read valid");
    property p_qt; !regRead |=> !regRvalid && regRdata == 8'h00; endproperty
    a_qt: assert property (p_qt) else $error("idle read port");
    property p_rb;
        regRead && regAddr == REG_FUNCPOL |=> regRdata == $past(fnQ);
    endproperty
    a_rb: assert property (p_rb) else $error("readback");
    property p_cnt;
        regWrite && regAddr == REG_MANT |->
            ##2 mantCount == $past(regWdata, 2);
    endproperty
    a_cnt: assert property (p_cnt) else $error("count view");
    property p_fa;
        !$past(rst) |-> funcDrvA == $past(funcOutA ^ fnAct[3:0]);
    endproperty
    a_fa: assert property (p_fa) else $error("func A");
    property p_fb;
        !$past(rst) |-> funcDrvB == $past(funcOutB ^ fnAct[7:4]);
    endproperty
    a_fb: assert property (p_fb) else $error("func B");
    property p_sg;
        !$past(rst) |-> signDrv == $past(signOut ^ sgAct[7:4]);
    endproperty
    a_sg: assert property (p_sg) else $error("signs");
    property p_ax;
        !$past(rst) |-> auxDrv == $past(auxOut ^ sgAct[3:0]);
    endproperty
    a_ax: assert property (p_ax) else $error("aux port");
endmodule
bind bpc_regs bpc_asserts bpc_asserts_i (.clk, .rst, .regWrite, .regRead,
    .regAddr, .regWdata, .regRdata, .regRvalid, .mantCount, .xferStart,
    .funcOutA, .funcOutB, .funcDrvA, .funcDrvB, .signOut, .signDrv,
    .auxOut, .auxDrv);
`default_nettype wire

// >>> dv/bpc_instr.sv
// Instrument model that drives the digit, sign and port pins.
`timescale 1ns/10ps
`default_nettype none
module bpc_instr (
    // Clock.
    input wire logic clk,
    // Instrument sense and logical word.
    input wire logic [23:0] negTrue,
    input wire logic [23:0] word,
    // Pin levels.
    output logic [23:0] pins
);
    // A negative-true line carries the inverse of its logical bit.
    always_ff @(posedge clk) begin
        pins <= word ^ negTrue;
    end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench of the polarity and format register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import bpc_pkg::*;
;
    localparam logic [7:0] DFLT [8] = '{8'h44, 8'h00, 8'h11, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] FMT [8] = '{8'h05, 8'h02, 8'h02, 8'h04,
        8'h22, 8'h21, 8'h11, 8'h00};
    localparam logic [23:0] PAT [2] = '{24'hF00F5A, 24'h0FF0A5};
    logic clk = 1'b0, rst = 1'b1;
    logic sw = 1'b1;
    logic regWrite = 1'b0, regRead = 1'b0, xferStart = 1'b0, regRvalid;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00, regRdata;
    logic [23:0] outs = 24'h5A0FC3, word = 24'h3C96A5, inst = 24'h0, pins;
    wire logic [23:0] drv, inw;
    // Count and sense views: mant, expo, func, decimal, handshake.
    wire logic [39:0] views;
    int failures = 0, cmp_count = 0;
    // Lines pack as func B, func A, data B, data A, signs, aux.
    bpc_regs bpc_regs_i (.clk, .rst, .resetDefaultConfigSwitch(sw),
        .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regRvalid,
        .xferStart, .funcPinA(pins[19:16]), .funcPinB(pins[23:20]),
        .funcOutA(outs[19:16]), .funcOutB(outs[23:20]),
        .funcInA(inw[19:16]), .funcInB(inw[23:20]),
        .funcDrvA(drv[19:16]), .funcDrvB(drv[23:20]),
        .dataPinA(pins[11:8]), .dataPinB(pins[15:12]),
        .dataOutA(outs[11:8]), .dataOutB(outs[15:12]),
        .dataInA(inw[11:8]), .dataInB(inw[15:12]),
        .dataDrvA(drv[11:8]), .dataDrvB(drv[15:12]),
        .signPin(pins[7:4]), .signOut(outs[7:4]), .signIn(inw[7:4]),
        .signDrv(drv[7:4]), .auxPin(pins[3:0]), .auxOut(outs[3:0]),
        .auxIn(inw[3:0]), .auxDrv(drv[3:0]), .mantCount(views[39:32]),
        .expoCount(views[31:24]), .funcCount(views[23:16]),
        .decPoint(views[15:8]), .handshakePol(views[7:0]));
    bpc_instr bpc_instr_i (.clk, .negTrue(inst), .word, .pins);
    // The clock toggles every half period of 12.5 ns.
    always #12.5 clk = ~clk;
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) #2;
        {regWrite, regAddr, regWdata} = {1'b1, a, d};
        @(posedge clk) #2;
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk) #2;
        {regRead, regAddr} = {1'b1, a};
        @(posedge clk) #2;
        regRead = 1'b0;
        check({15'h0, regRvalid, regRdata}, {16'h1, e});
    endtask
    task automatic pulse;
        @(posedge clk) #2;
        xferStart = 1'b1;
        @(posedge clk) #2;
        xferStart = 1'b0;
    endtask
    // The instrument follows sense s; logic reads back its word.
    task automatic lines(input logic [23:0] s);
        inst = s;
        repeat (5) @(posedge clk);
        #2;
        check(drv, outs ^ s);
        check(inw, word);
    endtask
    task automatic stop_test;
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence: defaults, formats, polarities, second reset.
    initial begin
        repeat (6) @(posedge clk);
        #2 rst = 1'b0;
        for (int i = 0; i < 8; i++) rd(4'(i + 3), DFLT[i]);
        check(views[39:16], {MANT_DUAL, EXPO_DUAL, FUNC_DUAL});
        check({8'h00, views[15:0]}, 24'h000000);
        wr(REG_ID, 8'hFF);
        rd(REG_ID, ID_VALUE);
        rd(4'hB, 8'h00);
        wr(REG_HSPOL, 8'h96);
        rd(REG_HSPOL, 8'h96);
        check({16'h0, views[7:0]}, 24'h000096);
        for (int j = 0; j < 8; j++) begin
            wr(4'(j % 4 + 3), FMT[j]);
            rd(4'(j % 4 + 3), FMT[j]);
            check({16'h0, views[39 - 8 * (j % 4) -: 8]},
                {16'h0, FMT[j]});
        end
        wr(REG_FUNC, 8'hCC);
        rd(REG_FUNC, 8'hBB);
        foreach (PAT[k]) begin
            wr(REG_FUNCPOL, PAT[k][23:16]);
            wr(REG_DATAPOL, PAT[k][15:8]);
            wr(REG_SIGNPOL, PAT[k][7:0]);
            lines(k ? PAT[0] : 24'h0);
            pulse;
            lines(PAT[k]);
            rd(REG_SIGNPOL, PAT[k][7:0]);
        end
        rst = 1'b1;
        repeat (6) @(posedge clk);
        #2 rst = 1'b0;
        rd(REG_SIGNPOL, 8'h00);
        rd(REG_MANT, 8'h44);
        rd(REG_HSPOL, 8'h00);
        lines(24'h0);
        // Single-channel strap: reset must load the single defaults.
        sw = 1'b0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        #2 rst = 1'b0;
        rd(REG_MANT, MANT_SINGLE);
        rd(REG_EXPO, EXPO_SINGLE);
        rd(REG_FUNC, FUNC_SINGLE);
        stop_test;
    end
    // The tests take about 140 cycles; 50 us is ample.
    initial begin
        #50us;
        failures++;
        stop_test;
    end
endmodule
`default_nettype wire
